/* File: plc_host_model.sv */
// host controller model for the serial control port
module plc_host_model (
  input wire logic core_clk,
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_sdi,
  input wire logic spi_sdo_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] dummy;
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi = 1'b0;
  end
  // step n edges, then move just off the edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // one frame msb first; fewer than 24 bits aborts it
  task automatic frame(input logic rw, input logic [14:0] adr, input logic [7:0] wd, input int nb,
    output logic [7:0] rdat);
    logic [23:0] f;
    f = {rw, adr, wd};
    rdat = 8'h00;
    spi_cs_n = 1'b0;
    for (int i = 23; i > 23 - nb; i--) begin
      spi_sclk = 1'b0;
      spi_sdi = f[i];
      wait_clk(4);
      if (i < 8) rdat[i] = spi_sdo_line;
      spi_sclk = 1'b1;
      wait_clk(3);
    end
    spi_sclk = 1'b0;
    wait_clk(2);
    spi_cs_n = 1'b1;
    // released line flips so a stale bit cannot pass
    spi_sdi = ~spi_sdi;
    wait_clk(3);
  endtask
  task automatic wake(input logic [7:0] loopv);
    frame(1'b0, 15'h001e, loopv, 24, dummy);
    frame(1'b0, 15'h0010, 8'h00, 24, dummy);
  endtask
endmodule

/* File: plc_map.vh */
// register map and field constants for the synthesizer loop control slice
`ifndef PLC_MAP_VH
`define PLC_MAP_VH

// ----------------------------------------------------------------
// serial frame layout
// ----------------------------------------------------------------
`define PLC_ADDR_W 15
`define PLC_FRAME_BITS 5'h18
`define PLC_ADDR_DONE 5'h10

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PLC_OFS_RELOCK 15'h0010
`define PLC_OFS_LOOP 15'h001e
`define PLC_OFS_REFERENCE_DIVIDER_OUTPUT 15'h001f
`define PLC_OFS_DIAG 15'h0020

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define PLC_RST_LOOP 8'h00
`define PLC_RST_REFERENCE_DIVIDER_OUTPUT 8'h00
`define PLC_RST_DIAG 8'h00
`define PLC_MASK_REFERENCE_DIVIDER_OUTPUT 8'h1f
`define PLC_MASK_DIAG 8'hfc

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PLC_LOOP_CUR_HI 7
`define PLC_LOOP_CUR_LO 4
`define PLC_LOOP_POL 3
`define PLC_LOOP_PD 2
`define PLC_LOOP_HOLD 0
`define PLC_DIAG_CODE_HI 7
`define PLC_DIAG_CODE_LO 4
`define PLC_DIAG_SHARE 3
`define PLC_DIAG_LEVEL 2

// ----------------------------------------------------------------
// diagnostic selector codes
// ----------------------------------------------------------------
`define PLC_MUX_TRISTATE 4'h0
`define PLC_MUX_LOCK 4'h1
`define PLC_MUX_UP 4'h2
`define PLC_MUX_DOWN 4'h3
`define PLC_MUX_RDIV2 4'h4
`define PLC_MUX_NDIV2 4'h5
`define PLC_MUX_VCO 4'h6
`define PLC_MUX_HIGH 4'h8

`endif

/* File: plc_ref_div.v */
// reference divider with hold, driven by reference ticks
module plc_ref_div #(
  parameter CNT_W = 5
) (
  core_clk,
  sys_rst,
  clk_en,
  ref_tick,
  div_count,
  hold,
  div_pulse,
  div_half
);
  input wire core_clk;
  input wire sys_rst;
  input wire clk_en;
  input wire ref_tick; // one pulse per reference period
  input wire [CNT_W-1:0] div_count; // programmed ratio, zero means full range
  input wire hold; // keeps counter cleared
  output reg div_pulse; // one pulse per divided period
  output reg div_half; // divided output over two

  reg [CNT_W-1:0] cnt_r; // ticks seen in current period

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // the terminal value is count minus one; zero wraps to all ones,
  // which gives the full two to the width division for free
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= {CNT_W{1'b0}};
      div_pulse <= 1'b0;
      div_half <= 1'b0;
    end else if (clk_en) begin
      if (hold) begin
        cnt_r <= {CNT_W{1'b0}};
        div_pulse <= 1'b0;
        div_half <= 1'b0;
      end else if (ref_tick) begin
        if (cnt_r == div_count - {{(CNT_W-1){1'b0}}, 1'b1}) begin
          cnt_r <= {CNT_W{1'b0}};
          div_pulse <= 1'b1;
          div_half <= ~div_half;
        end else begin
          cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
          div_pulse <= 1'b0;
        end
      end else begin
        div_pulse <= 1'b0;
      end
    end
  end
endmodule

/* File: plc_top.v */
// loop and diagnostic control registers behind the serial control port
`include "plc_map.vh"

module plc_top #(
  parameter RCNT_W = 5
) (
  core_clk,
  sys_rst,
  clk_en,
  spi_cs_n,
  spi_sclk,
  spi_sdi,
  spi_sdo_out,
  spi_sdo_oe,
  ref_tick,
  fb_tick,
  lock_detect,
  pump_up,
  pump_down,
  vco_test,
  pump_current_code,
  detector_polarity,
  synth_power_down,
  divider_counter_hold,
  diagnostic_level_select,
  relock_request,
  pfd_ref_pulse,
  pfd_fb_pulse
);
  input wire core_clk;
  input wire sys_rst;
  input wire clk_en; // freezes all state while low
  input wire spi_cs_n; // frame select, low active
  input wire spi_sclk; // serial clock, sampled as a plain input
  input wire spi_sdi; // serial data in
  output reg spi_sdo_out; // data-out pin level
  output reg spi_sdo_oe; // data-out pin driven while high
  input wire ref_tick; // reference clock tick
  input wire fb_tick; // feedback divider tick
  input wire lock_detect; // digital lock detect
  input wire pump_up; // charge pump up
  input wire pump_down; // charge pump down
  input wire vco_test; // vco test signal
  output reg [3:0] pump_current_code; // 0.35 mA per step plus 0.35 mA
  output reg detector_polarity; // 1 positive
  output reg synth_power_down; // 1 synthesizer blocks off
  output reg divider_counter_hold; // 1 counters held
  output reg diagnostic_level_select; // 1 for 3.3 V, 0 for 1.8 V
  output reg relock_request; // pulse on write to relock register
  output reg pfd_ref_pulse; // divided reference to detector
  output reg pfd_fb_pulse; // feedback to detector

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [7:0] loop_ctrl_r; // charge_pump_loop_control
  reg [7:0] reference_divider_output_r; // reference_divider_count
  reg [7:0] diag_r; // diagnostic_output_select
  reg sclk_q_r; // previous serial clock level
  reg [4:0] bit_cnt_r; // bits received this frame
  reg [23:0] in_sh_r; // incoming shift
  reg [7:0] out_sh_r; // readback shift
  reg fb_half_r; // feedback divided by two
  reg rd_frm_r; // frame is a read, latched once the address is in
  wire sclk_rise; // rising serial edge
  wire sclk_fall; // falling serial edge
  wire [23:0] in_nxt; // shift after current bit
  wire frame_rd; // frame is a read
  wire [`PLC_ADDR_W-1:0] frame_addr; // address of frame
  wire hold_all; // counters must stay idle
  wire reference_divider_output_pulse; // reference divider output
  wire reference_divider_output_half; // reference divider over two
  reg diag_bit; // selected diagnostic level
  reg [7:0] rd_data; // readback value

  assign sclk_rise = spi_sclk & ~sclk_q_r;
  assign sclk_fall = ~spi_sclk & sclk_q_r;
  assign in_nxt = {in_sh_r[22:0], spi_sdi};
  assign frame_rd = in_nxt[23];
  assign frame_addr = in_nxt[22:8];

  // ----------------------------------------------------------------
  // readback decode, used by read frames
  // ----------------------------------------------------------------
  // unmapped addresses read as zero
  function [7:0] reg_value;
    input [`PLC_ADDR_W-1:0] a;
    input [7:0] lc;
    input [7:0] rd;
    input [7:0] dg;
    begin
      case (a)
        `PLC_OFS_LOOP: reg_value = lc;
        `PLC_OFS_REFERENCE_DIVIDER_OUTPUT: reg_value = rd & `PLC_MASK_REFERENCE_DIVIDER_OUTPUT;
        `PLC_OFS_DIAG: reg_value = dg & `PLC_MASK_DIAG;
        default: reg_value = 8'h00;
      endcase
    end
  endfunction

  // the sixteenth bit completes the address, so it sits in the low bits
  always @* begin
    rd_data = reg_value(in_nxt[`PLC_ADDR_W-1:0], loop_ctrl_r, reference_divider_output_r, diag_r);
  end

  // ----------------------------------------------------------------
  // serial port and register writes
  // ----------------------------------------------------------------
  // frame is read bit, 15 address bits, 8 data bits, msb first;
  // data in taken on sclk rise, readback shifted out on sclk fall
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q_r <= 1'b0;
      bit_cnt_r <= 5'h00;
      in_sh_r <= 24'h000000;
      out_sh_r <= 8'h00;
      rd_frm_r <= 1'b0;
      loop_ctrl_r <= `PLC_RST_LOOP;
      reference_divider_output_r <= `PLC_RST_REFERENCE_DIVIDER_OUTPUT;
      diag_r <= `PLC_RST_DIAG;
      relock_request <= 1'b0;
    end else if (clk_en) begin
      sclk_q_r <= spi_sclk;
      relock_request <= 1'b0;
      if (spi_cs_n) begin
        // idle: a partial frame is dropped
        bit_cnt_r <= 5'h00;
        rd_frm_r <= 1'b0;
      end else if (sclk_rise) begin
        in_sh_r <= in_nxt;
        bit_cnt_r <= bit_cnt_r + 5'h01;
        // address complete: pick up readback byte
        if (bit_cnt_r == `PLC_ADDR_DONE - 5'h01) begin
          out_sh_r <= rd_data;
          rd_frm_r <= in_nxt[15];
        end
        // last bit: commit a write
        if (bit_cnt_r == `PLC_FRAME_BITS - 5'h01 && !frame_rd) begin
          case (frame_addr)
            // full byte for loop, masked byte for divider and diagnostic
            `PLC_OFS_LOOP: loop_ctrl_r <= in_nxt[7:0];
            `PLC_OFS_REFERENCE_DIVIDER_OUTPUT: reference_divider_output_r <= in_nxt[7:0] & `PLC_MASK_REFERENCE_DIVIDER_OUTPUT;
            `PLC_OFS_DIAG: diag_r <= in_nxt[7:0] & `PLC_MASK_DIAG;
            `PLC_OFS_RELOCK: relock_request <= 1'b1;
            default: relock_request <= 1'b0;
          endcase
        end
      end else if (sclk_fall && bit_cnt_r >= `PLC_ADDR_DONE) begin
        out_sh_r <= {out_sh_r[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  // power-down leaves all register storage untouched, so a host can
  // park the synthesizer and bring it back without reprogramming
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pump_current_code <= 4'h0;
      detector_polarity <= 1'b0;
      synth_power_down <= 1'b0;
      divider_counter_hold <= 1'b0;
      diagnostic_level_select <= 1'b0;
    end else if (clk_en) begin
      pump_current_code <= loop_ctrl_r[`PLC_LOOP_CUR_HI:`PLC_LOOP_CUR_LO];
      detector_polarity <= loop_ctrl_r[`PLC_LOOP_POL];
      synth_power_down <= loop_ctrl_r[`PLC_LOOP_PD];
      divider_counter_hold <= loop_ctrl_r[`PLC_LOOP_HOLD];
      diagnostic_level_select <= diag_r[`PLC_DIAG_LEVEL];
    end
  end

  // a powered-down synthesizer also stops its dividers
  assign hold_all = loop_ctrl_r[`PLC_LOOP_HOLD] | loop_ctrl_r[`PLC_LOOP_PD];

  // ----------------------------------------------------------------
  // dividers and detector feed
  // ----------------------------------------------------------------
  plc_ref_div #(
    .CNT_W(RCNT_W)
  ) u_ref_div (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .ref_tick(ref_tick),
    .div_count(reference_divider_output_r[RCNT_W-1:0]),
    .hold(hold_all),
    .div_pulse(reference_divider_output_pulse),
    .div_half(reference_divider_output_half)
  );

  // feedback toggle and detector gating
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fb_half_r <= 1'b0;
      pfd_ref_pulse <= 1'b0;
      pfd_fb_pulse <= 1'b0;
    end else if (clk_en) begin
      if (hold_all) begin
        fb_half_r <= 1'b0;
        pfd_ref_pulse <= 1'b0;
        pfd_fb_pulse <= 1'b0;
      end else begin
        if (fb_tick) begin
          fb_half_r <= ~fb_half_r;
        end
        pfd_ref_pulse <= reference_divider_output_pulse;
        pfd_fb_pulse <= fb_tick;
      end
    end
  end

  // ----------------------------------------------------------------
  // diagnostic selector
  // ----------------------------------------------------------------
  // unlisted codes give low rather than an undefined level
  always @* begin
    case (diag_r[`PLC_DIAG_CODE_HI:`PLC_DIAG_CODE_LO])
      `PLC_MUX_LOCK: diag_bit = lock_detect;
      `PLC_MUX_UP: diag_bit = pump_up;
      `PLC_MUX_DOWN: diag_bit = pump_down;
      `PLC_MUX_RDIV2: diag_bit = reference_divider_output_half;
      `PLC_MUX_NDIV2: diag_bit = fb_half_r;
      `PLC_MUX_VCO: diag_bit = vco_test;
      `PLC_MUX_HIGH: diag_bit = 1'b1;
      default: diag_bit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // data-out pin
  // ----------------------------------------------------------------
  // tristate code only floats the pin in readback role; in the
  // diagnostic role the pin is always driven
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      spi_sdo_out <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else if (clk_en) begin
      if (diag_r[`PLC_DIAG_SHARE]) begin
        spi_sdo_out <= diag_bit;
        spi_sdo_oe <= 1'b1;
      // the read bit moves up one place in the shift on every rise, so the
      // data phase keys on its own latched flag
      end else if (!spi_cs_n && rd_frm_r && bit_cnt_r >= `PLC_ADDR_DONE) begin
        // read frame data phase
        if (sclk_fall) begin
          spi_sdo_out <= out_sh_r[7];
        end
        spi_sdo_oe <= 1'b1;
      end else begin
        spi_sdo_out <= 1'b0;
        spi_sdo_oe <= 1'b0;
      end
    end
  end
endmodule

/* File: plc_top_props.sv */
// port-level property checker for the loop control block
module plc_top_props (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic spi_cs_n,
  input wire logic spi_sdo_oe,
  input wire logic ref_tick,
  input wire logic fb_tick,
  input wire logic [3:0] pump_current_code,
  input wire logic detector_polarity,
  input wire logic synth_power_down,
  input wire logic divider_counter_hold,
  input wire logic diagnostic_level_select,
  input wire logic relock_request,
  input wire logic pfd_ref_pulse,
  input wire logic pfd_fb_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // detector feed
  // ----------------------------------------------------------------
  property p_hold_quiet;
    divider_counter_hold [*3] |-> !pfd_ref_pulse && !pfd_fb_pulse;
  endproperty
  a_hold_quiet: assert property (p_hold_quiet) else $error("pulse while held");
  property p_pd_quiet;
    synth_power_down [*3] |-> !pfd_ref_pulse && !pfd_fb_pulse;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("pulse while powered down");
  property p_fb_follow;
    (spi_cs_n && !divider_counter_hold && !synth_power_down) [*3] ##0 fb_tick |=> pfd_fb_pulse;
  endproperty
  a_fb_follow: assert property (p_fb_follow) else $error("feedback tick lost");
  property p_fb_cause;
    pfd_fb_pulse |-> $past(fb_tick);
  endproperty
  a_fb_cause: assert property (p_fb_cause) else $error("feedback pulse without tick");
  property p_ref_cause;
    pfd_ref_pulse |-> $past(ref_tick, 2);
  endproperty
  a_ref_cause: assert property (p_ref_cause) else $error("reference pulse without tick");
  // ----------------------------------------------------------------
  // register side effects only near a frame
  // ----------------------------------------------------------------
  property p_oe_rise;
    $rose(spi_sdo_oe) |-> !$past(spi_cs_n) || !$past(spi_cs_n, 2) || !$past(spi_cs_n, 3);
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("data-out enabled outside a frame");
  property p_ctl_quiet;
    !$stable({pump_current_code, detector_polarity, synth_power_down, divider_counter_hold,
      diagnostic_level_select}) |-> !$past(spi_cs_n) || !$past(spi_cs_n, 2) || !$past(spi_cs_n, 3);
  endproperty
  a_ctl_quiet: assert property (p_ctl_quiet) else $error("control changed outside a frame");
  property p_relock_pulse;
    relock_request |-> (!$past(spi_cs_n) || !$past(spi_cs_n, 2)) ##1 !relock_request;
  endproperty
  a_relock_pulse: assert property (p_relock_pulse) else $error("bad relock pulse");
endmodule

bind plc_top plc_top_props u_plc_top_props (.core_clk(core_clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n),
  .spi_sdo_oe(spi_sdo_oe), .ref_tick(ref_tick), .fb_tick(fb_tick), .pump_current_code(pump_current_code),
  .detector_polarity(detector_polarity), .synth_power_down(synth_power_down),
  .divider_counter_hold(divider_counter_hold), .diagnostic_level_select(diagnostic_level_select),
  .relock_request(relock_request), .pfd_ref_pulse(pfd_ref_pulse), .pfd_fb_pulse(pfd_fb_pulse));

/* File: plc_top_tb.sv */
// self-checking bench for the loop control register slice
module plc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, sys_rst, clk_en, ref_tick, fb_tick, lock_detect, pump_up, pump_down, vco_test;
  wire spi_cs_n, spi_sclk, spi_sdi, spi_sdo_out, spi_sdo_oe, detector_polarity, synth_power_down;
  wire divider_counter_hold, diagnostic_level_select, relock_request, pfd_ref_pulse, pfd_fb_pulse;
  wire [3:0] pump_current_code;
  // undriven pin floats so a missing enable never reads as data
  wire spi_sdo_line = spi_sdo_oe ? spi_sdo_out : 1'bz;
  wire [7:0] ctl = {1'b0, pump_current_code, detector_polarity, synth_power_down, divider_counter_hold};
  int n_errors = 0;
  int checks = 0;
  int n_ref = 0;
  int n_fb = 0;
  int n_relock = 0;
  logic [7:0] rd;
  plc_top u_plc_top (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo_out(spi_sdo_out), .spi_sdo_oe(spi_sdo_oe),
    .ref_tick(ref_tick), .fb_tick(fb_tick), .lock_detect(lock_detect), .pump_up(pump_up),
    .pump_down(pump_down), .vco_test(vco_test), .pump_current_code(pump_current_code),
    .detector_polarity(detector_polarity), .synth_power_down(synth_power_down),
    .divider_counter_hold(divider_counter_hold), .diagnostic_level_select(diagnostic_level_select),
    .relock_request(relock_request), .pfd_ref_pulse(pfd_ref_pulse), .pfd_fb_pulse(pfd_fb_pulse));
  plc_host_model u_plc_host_model (.core_clk(core_clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_sdi(spi_sdi), .spi_sdo_line(spi_sdo_line));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // pulse counters, sampled before each edge's updates land
  always @(posedge core_clk) begin
    n_ref += (pfd_ref_pulse === 1'b1);
    n_fb += (pfd_fb_pulse === 1'b1);
    n_relock += (relock_request === 1'b1);
  end
  task automatic test_done();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    test_done();
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    u_plc_host_model.frame(1'b0, a, d, 24, rd);
  endtask
  task automatic rchk(input logic [14:0] a, input logic [7:0] exp);
    u_plc_host_model.frame(1'b1, a, 8'h00, 24, rd);
    chk("readback", exp, rd);
  endtask
  // one tick on both divider inputs every other cycle
  task automatic ticks(input int n);
    repeat (n) begin
      {ref_tick, fb_tick} = 2'b11;
      u_plc_host_model.wait_clk(1);
      {ref_tick, fb_tick} = 2'b00;
      u_plc_host_model.wait_clk(1);
    end
    u_plc_host_model.wait_clk(4);
  endtask
  function automatic logic dmux(input logic [3:0] c);
    case (c)
      4'h1: return lock_detect;
      4'h2: return pump_up;
      4'h3: return pump_down;
      4'h6: return vco_test;
      4'h8: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  initial begin
    logic [7:0] lv [3] = '{8'hb9, 8'h46, 8'hf2};
    logic [4:0] rv [3] = '{5'h03, 5'h00, 5'h01};
    logic [3:0] mc [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8};
    int s0, f0, e;
    logic x, tg;
    {sys_rst, clk_en, ref_tick, fb_tick} = 4'b1100;
    {lock_detect, pump_up, pump_down, vco_test} = 4'h0;
    repeat (12) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    u_plc_host_model.wait_clk(2);
    chk("outputs", 8'h00, ctl);
    for (int a = 30; a < 33; a++) rchk(15'(a), 8'h00);
    $display("test reset done");
    foreach (lv[k]) begin
      wr(15'h001e, lv[k]);
      rchk(15'h001e, lv[k]);
      chk("loop outputs", {1'b0, lv[k][7:2], lv[k][0]}, ctl);
    end
    $display("test loop control done");
    wr(15'h001f, 8'hff);
    rchk(15'h001f, 8'h1f);
    wr(15'h0020, 8'hf7);
    rchk(15'h0020, 8'hf4);
    chk("level", 8'h01, {7'h00, diagnostic_level_select});
    wr(15'h0021, 8'ha5);
    rchk(15'h0021, 8'h00);
    u_plc_host_model.frame(1'b0, 15'h001f, 8'h0a, 20, rd);
    rchk(15'h001f, 8'h1f);
    $display("test fields done");
    wr(15'h001e, 8'h04);
    chk("loop outputs", 8'h02, ctl);
    rchk(15'h001f, 8'h1f);
    rchk(15'h0020, 8'hf4);
    s0 = n_ref + n_fb;
    ticks(40);
    chk("pulses powered down", 8'h00, 8'(n_ref + n_fb - s0));
    s0 = n_relock;
    u_plc_host_model.wake(8'h01);
    chk("relock pulses", 8'h01, 8'(n_relock - s0));
    s0 = n_ref + n_fb;
    ticks(40);
    chk("pulses held", 8'h00, 8'(n_ref + n_fb - s0));
    $display("test power and hold done");
    foreach (rv[k]) begin
      e = (rv[k] == 5'h00) ? 32 : int'(rv[k]);
      wr(15'h001e, 8'h01);
      wr(15'h001f, {3'h0, rv[k]});
      wr(15'h001e, 8'h08);
      s0 = n_ref;
      f0 = n_fb;
      ticks(2 * e);
      chk("ref pulses", 8'h02, 8'(n_ref - s0));
      chk("fb pulses", 8'(2 * e), 8'(n_fb - f0));
    end
    $display("test divider done");
    // a frozen core ignores whole frames and keeps every output
    clk_en = 1'b0;
    wr(15'h001f, 8'h07);
    wr(15'h001e, 8'h04);
    chk("frozen outputs", 8'h04, ctl);
    clk_en = 1'b1;
    u_plc_host_model.wait_clk(2);
    rchk(15'h001f, 8'h01);
    rchk(15'h001e, 8'h08);
    $display("test clock enable done");
    foreach (mc[k]) begin
      wr(15'h0020, {mc[k], 4'h8});
      for (int p = 0; p < 2; p++) begin
        {lock_detect, pump_up, pump_down, vco_test} = p ? 4'h5 : 4'ha;
        tg = (mc[k][3:1] == 3'h2);
        x = tg ? ~spi_sdo_line : dmux(mc[k]);
        if (tg) ticks(1);
        else u_plc_host_model.wait_clk(3);
        chk("diag pin", {6'h00, 1'b1, x}, {6'h00, spi_sdo_oe, spi_sdo_line});
      end
    end
    wr(15'h0020, 8'h04);
    rchk(15'h0020, 8'h04);
    chk("pin idle", 8'h00, {7'h00, spi_sdo_oe});
    $display("test diagnostic done");
    test_done();
  end
endmodule
